// ===== osp_pkg.sv
// Constants and register map of the one-shot pulse pair
package osp_pkg;
  localparam int          DW           = 16;
  localparam int          AW           = 4;
  localparam logic [AW-1:0] ADR_ENABLE = 4'h0; // bit0 unit power enable
  localparam logic [AW-1:0] ADR_PRESC  = 4'h1; // [3:0] tick a divider, [7:4] tick b divider
  localparam logic [AW-1:0] ADR_MMODE  = 4'h2; // master mode config
  localparam logic [AW-1:0] ADR_SMODE  = 4'h3; // slave mode config
  localparam logic [AW-1:0] ADR_MRLD   = 4'h4; // master reload value
  localparam logic [AW-1:0] ADR_SRLD   = 4'h5; // slave reload value
  localparam logic [AW-1:0] ADR_START  = 4'h6; // bit0 master, bit1 slave start
  localparam logic [AW-1:0] ADR_STOP   = 4'h7; // bit0 master, bit1 slave stop
  localparam logic [AW-1:0] ADR_OUTCFG = 4'h8; // see OC_ fields
  localparam logic [AW-1:0] ADR_STATUS = 4'h9; // see ST_ fields
  localparam logic [AW-1:0] ADR_MCNT   = 4'hA; // master down counter
  localparam logic [AW-1:0] ADR_SCNT   = 4'hB; // slave down counter
  localparam logic [AW-1:0] ADR_PORT   = 4'hC; // bit0 port output mode, bit1 port latch
  localparam int OC_LEVEL = 0;
  localparam int OC_OE    = 1;
  localparam int OC_POL   = 2;
  localparam int OC_SMODE = 3;
  localparam int OC_MMODE = 4;
  localparam int OC_FILT  = 5;
  localparam int ST_MRUN  = 0;
  localparam int ST_SRUN  = 1;
  localparam int ST_MDONE = 2;
  localparam int ST_SDONE = 3;
  localparam int MD_CKS_LO = 14;
  localparam int MD_LEADER = 11;
  localparam logic [1:0] CKS_A = 2'h0;
  localparam logic [1:0] CKS_B = 2'h2;
  localparam logic [DW-1:0] CNT_ZERO = 16'h0000;
  localparam logic [DW-1:0] CNT_ONE  = 16'h0001;
  localparam logic [3:0]    DIV_ZERO = 4'h0;
  localparam int FILT_LEN = 2;
  typedef enum logic [1:0] {OSP_IDLE, OSP_WAIT, OSP_COUNT} osp_state_e;
endpackage : osp_pkg

// ===== osp_prescaler.sv
// Power-of-two prescaler giving two count tick strobes
`timescale 1ns/10ps
module osp_prescaler
  import osp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       run,
  input  wire logic [3:0] div_a,
  input  wire logic [3:0] div_b,
  output logic            tick_a,
  output logic            tick_b
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic        tick_a_d;
  logic        tick_b_d;

  function automatic logic hit(input logic [15:0] c, input logic [3:0] d);
    logic [15:0] m;
    m = (16'h0001 << d) - 16'h0001;
    hit = ((c & m) == m);
  endfunction : hit

  always_comb
  begin
    cnt_d    = run ? cnt_q + 16'h0001 : 16'h0000;
    tick_a_d = run && hit(cnt_q, div_a);
    tick_b_d = run && hit(cnt_q, div_b);
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      cnt_q  <= 16'h0000;
      tick_a <= 1'b0;
      tick_b <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      tick_a <= tick_a_d;
      tick_b <= tick_b_d;
    end
  end
endmodule : osp_prescaler

// ===== osp_trigger_sync.sv
// Trigger pin synchroniser, optional filter and rising edge detector
`timescale 1ns/10ps
module osp_trigger_sync
  import osp_pkg::*;
(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic pin,
  input  wire logic filt_en,
  output logic      edge_pulse
);
  logic                meta_q;
  logic                sync_q;
  logic [FILT_LEN-1:0] hist_q;
  logic                lvl_q;
  logic                lvl_d;
  logic                edge_d;

  // Filter needs the level stable for the history length plus the current sample
  always_comb
  begin
    if (!filt_en)
      lvl_d = sync_q;
    else if (&{hist_q, sync_q})
      lvl_d = 1'b1;
    else if (~|{hist_q, sync_q})
      lvl_d = 1'b0;
    else
      lvl_d = lvl_q;
    edge_d = lvl_d & ~lvl_q; // R26
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      meta_q     <= 1'b0;
      sync_q     <= 1'b0;
      hist_q     <= '0;
      lvl_q      <= 1'b0;
      edge_pulse <= 1'b0;
    end
    else
    begin
      meta_q     <= pin;
      sync_q     <= meta_q; // R26
      hist_q     <= {hist_q[FILT_LEN-2:0], sync_q};
      lvl_q      <= lvl_d;
      edge_pulse <= edge_d;
    end
  end
endmodule : osp_trigger_sync

// ===== osp_pulse_pair.sv
// One-shot pulse pair: master delay channel and slave width channel
// What this block does
// R1 - Trigger to pulse start is master reload plus 2 count ticks.
// R2 - Pulse lasts exactly slave reload count ticks.
// R3 - Master one-count: each trigger loads master reload and starts counting.
// R4 - Master decrements per tick; at zero raises done and halts.
// R5 - Slave one-count, started by master done, loads slave reload.
// R6 - Slave decrements per tick; at zero raises done and waits.
// R7 - Output active one tick after master done, inactive at slave zero.
// R8 - Software master start while running acts as a trigger.
// R9 - Software changes reloads only after the matching done event.
// R10 - Pair uses even master channel and higher slave channel up to 7.
// R11 - Clock select 00B picks tick a, 10B picks tick b.
// R12 - Leader select bit set for masters on channels 2, 4, 6.
// R13 - Slave clock select programmed same as master.
// R14 - Output level bit sets pulse output low or high.
// R15 - Output enable lets counting change the output; 0 blocks it.
// R16 - Polarity 0 active high, 1 active low.
// R17 - Software sets master output mode 0, slave output mode 1.
// R18 - Unit enable 0 stops clock and ignores writes; 1 allows, all stopped.
// R19 - Prescaler select sets both tick frequencies.
// R20 - Software enables the trigger input filter.
// R21 - Pin stays Hi-Z until port output mode with latch 0.
// R22 - While stopped, output holds software set level.
// R23 - Start bits set running flags, master waits trigger; read back 0.
// R24 - Stop bits clear flags, counters hold, read back 0.
// R25 - Software never starts the slave directly.
// R26 - Trigger pin synchronised; valid edge gives one-cycle start pulse.
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/10ps
module osp_pulse_pair
  import osp_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic          wr,
  input  wire logic          rd,
  output logic [DW-1:0]      rdata,
  input  wire logic          trigger_input_pin,
  output logic               pulse_output_pin,
  output logic               pulse_output_oe,
  output logic               master_done_irq,
  output logic               slave_done_irq
);
  logic            unit_power_enable_q, unit_power_enable_d;
  logic [7:0]      prescaler_select_q, prescaler_select_d;
  logic [DW-1:0]   master_mode_config_q, master_mode_config_d;
  logic [DW-1:0]   slave_mode_config_q, slave_mode_config_d;
  logic [DW-1:0]   master_reload_value_q, master_reload_value_d;
  logic [DW-1:0]   slave_reload_value_q, slave_reload_value_d;
  logic [5:0]      outcfg_q, outcfg_d;
  logic [1:0]      port_q, port_d;
  logic            level_q, level_d;
  logic            mdone_q, mdone_d;
  logic            sdone_q, sdone_d;
  logic [DW-1:0]   rdata_d;
  osp_state_e      mst_q, mst_d;
  logic            slave_running_q, slave_running_d;
  logic [DW-1:0]   master_down_counter_q, master_down_counter_d;
  logic [DW-1:0]   slave_down_counter_q, slave_down_counter_d;
  logic            slave_armed_q, slave_armed_d;
  logic            mirq_d, sirq_d;
  logic            pin_d, oe_d;
  logic            tick_a, tick_b, pin_edge;
  logic            wr_ok, mtick, stick, trig, sw_start;

  // Writes are only taken while the unit is powered, except writes to the enable register
  assign wr_ok = wr && (unit_power_enable_q || addr == ADR_ENABLE); // R18

  function automatic logic sel_tick(input logic [DW-1:0] mode, input logic ta,
                                    input logic tb);
    unique case (mode[MD_CKS_LO+1:MD_CKS_LO])
      CKS_A:   sel_tick = ta; // R11
      CKS_B:   sel_tick = tb; // R11
      default: sel_tick = 1'b0;
    endcase
  endfunction : sel_tick

  osp_prescaler u_presc (
    .clk    (clk),
    .rstn   (rstn && unit_power_enable_q), // R18
    .run    (unit_power_enable_q),
    .div_a  (prescaler_select_q[3:0]), // R19
    .div_b  (prescaler_select_q[7:4]), // R19
    .tick_a (tick_a),
    .tick_b (tick_b)
  );

  osp_trigger_sync u_trig (
    .clk        (clk),
    .rstn       (rstn),
    .pin        (trigger_input_pin),
    .filt_en    (outcfg_q[OC_FILT]),
    .edge_pulse (pin_edge)
  );

  assign mtick    = sel_tick(master_mode_config_q, tick_a, tick_b);
  assign stick    = sel_tick(slave_mode_config_q, tick_a, tick_b);
  assign sw_start = wr_ok && addr == ADR_START && wdata[0] && mst_q != OSP_IDLE; // R8
  assign trig     = pin_edge || sw_start;

  // Register file
  always_comb
  begin
    unit_power_enable_d   = unit_power_enable_q;
    prescaler_select_d    = prescaler_select_q;
    master_mode_config_d  = master_mode_config_q;
    slave_mode_config_d   = slave_mode_config_q;
    master_reload_value_d = master_reload_value_q;
    slave_reload_value_d  = slave_reload_value_q;
    outcfg_d              = outcfg_q;
    port_d                = port_q;
    if (wr_ok)
    begin
      unique case (addr)
        ADR_ENABLE: unit_power_enable_d   = wdata[0]; // R18
        ADR_PRESC:  prescaler_select_d    = wdata[7:0];
        ADR_MMODE:  master_mode_config_d  = wdata; // R10
        ADR_SMODE:  slave_mode_config_d   = wdata;
        ADR_MRLD:   master_reload_value_d = wdata;
        ADR_SRLD:   slave_reload_value_d  = wdata;
        ADR_OUTCFG: outcfg_d              = wdata[5:0];
        ADR_PORT:   port_d                = wdata[1:0];
        default:    ;
      endcase
    end
    unique case (addr)
      ADR_ENABLE: rdata_d = {15'h0000, unit_power_enable_q};
      ADR_PRESC:  rdata_d = {8'h00, prescaler_select_q};
      ADR_MMODE:  rdata_d = master_mode_config_q;
      ADR_SMODE:  rdata_d = slave_mode_config_q;
      ADR_MRLD:   rdata_d = master_reload_value_q;
      ADR_SRLD:   rdata_d = slave_reload_value_q;
      ADR_OUTCFG: rdata_d = {10'h000, outcfg_q[5:1], level_q};
      ADR_STATUS: rdata_d = {12'h000, sdone_q, mdone_q, slave_running_q, mst_q != OSP_IDLE};
      ADR_MCNT:   rdata_d = master_down_counter_q;
      ADR_SCNT:   rdata_d = slave_down_counter_q;
      ADR_PORT:   rdata_d = {14'h0000, port_q};
      default:    rdata_d = CNT_ZERO; // start/stop bits read 0 R23 R24
    endcase
    if (!rd)
      rdata_d = CNT_ZERO;
  end

  // Channels and output
  always_comb
  begin
    mst_d                 = mst_q;
    slave_running_d       = slave_running_q;
    master_down_counter_d = master_down_counter_q;
    slave_down_counter_d  = slave_down_counter_q;
    slave_armed_d         = slave_armed_q;
    level_d               = level_q;
    mirq_d                = 1'b0;
    sirq_d                = 1'b0;
    mdone_d               = mdone_q;
    sdone_d               = sdone_q;
    unique case (mst_q)
      OSP_IDLE: ;
      OSP_WAIT:
        if (trig)
        begin
          master_down_counter_d = master_reload_value_q; // R3
          mst_d                 = OSP_COUNT;
        end
      OSP_COUNT:
        if (trig)
          master_down_counter_d = master_reload_value_q; // R3
        else if (mtick)
        begin
          if (master_down_counter_q == CNT_ZERO)
          begin
            mirq_d        = 1'b1; // R4
            mst_d         = OSP_WAIT;
            slave_armed_d = slave_running_q; // R5
          end
          else
            master_down_counter_d = master_down_counter_q - CNT_ONE; // R4
        end
    endcase
    // Slave arms at master done, loads and goes active on its next tick R1 R7
    if (slave_running_q && stick)
    begin
      if (slave_armed_q)
      begin
        slave_armed_d        = 1'b0;
        // Full reload: the active level lasts one tick per count down to zero
        slave_down_counter_d = slave_reload_value_q; // R5 R2
        if (outcfg_q[OC_OE])
          level_d = ~outcfg_q[OC_POL]; // R7 R15 R16
        if (slave_reload_value_q == CNT_ZERO)
          slave_down_counter_d = CNT_ZERO;
      end
      else if (slave_down_counter_q != CNT_ZERO)
      begin
        slave_down_counter_d = slave_down_counter_q - CNT_ONE; // R6
        if (slave_down_counter_q == CNT_ONE)
        begin
          sirq_d = 1'b1; // R6
          if (outcfg_q[OC_OE])
            level_d = outcfg_q[OC_POL]; // R7 R2
        end
      end
    end
    if (mirq_d)
      mdone_d = 1'b1;
    if (sirq_d)
      sdone_d = 1'b1;
    if (wr_ok && addr == ADR_STATUS)
    begin
      mdone_d = (mdone_q & ~wdata[ST_MDONE]) | mirq_d; // set wins
      sdone_d = (sdone_q & ~wdata[ST_SDONE]) | sirq_d;
    end
    if (wr_ok && addr == ADR_START && wdata[0] && mst_q == OSP_IDLE)
    begin
      mst_d           = OSP_WAIT; // R23
      slave_running_d = wdata[1]; // R23
    end
    if (wr_ok && addr == ADR_STOP)
    begin
      if (wdata[0])
        mst_d = OSP_IDLE; // R24
      if (wdata[1])
      begin
        slave_running_d = 1'b0; // R24
        slave_armed_d   = 1'b0;
      end
    end
    // Software level only when counting may not drive the pin R14 R22
    if (wr_ok && addr == ADR_OUTCFG && !outcfg_q[OC_OE])
      level_d = wdata[OC_LEVEL]; // R14
    if (!unit_power_enable_q)
    begin
      mst_d           = OSP_IDLE; // R18
      slave_running_d = 1'b0;
      slave_armed_d   = 1'b0;
    end
    pin_d = level_q;
    oe_d  = port_q[0] && !port_q[1]; // R21
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      unit_power_enable_q   <= 1'b0;
      prescaler_select_q    <= 8'h00;
      master_mode_config_q  <= CNT_ZERO;
      slave_mode_config_q   <= CNT_ZERO;
      master_reload_value_q <= CNT_ZERO;
      slave_reload_value_q  <= CNT_ZERO;
      outcfg_q              <= 6'h00;
      port_q                <= 2'h0;
      level_q               <= 1'b0;
      mdone_q               <= 1'b0;
      sdone_q               <= 1'b0;
      rdata                 <= CNT_ZERO;
      mst_q                 <= OSP_IDLE;
      slave_running_q       <= 1'b0;
      master_down_counter_q <= CNT_ZERO;
      slave_down_counter_q  <= CNT_ZERO;
      slave_armed_q         <= 1'b0;
      master_done_irq       <= 1'b0;
      slave_done_irq        <= 1'b0;
      pulse_output_pin      <= 1'b0;
      pulse_output_oe       <= 1'b0;
    end
    else
    begin
      unit_power_enable_q   <= unit_power_enable_d;
      prescaler_select_q    <= prescaler_select_d;
      master_mode_config_q  <= master_mode_config_d;
      slave_mode_config_q   <= slave_mode_config_d;
      master_reload_value_q <= master_reload_value_d;
      slave_reload_value_q  <= slave_reload_value_d;
      outcfg_q              <= outcfg_d;
      port_q                <= port_d;
      level_q               <= level_d;
      mdone_q               <= mdone_d;
      sdone_q               <= sdone_d;
      rdata                 <= rdata_d;
      mst_q                 <= mst_d;
      slave_running_q       <= slave_running_d;
      master_down_counter_q <= master_down_counter_d;
      slave_down_counter_q  <= slave_down_counter_d;
      slave_armed_q         <= slave_armed_d;
      master_done_irq       <= mirq_d;
      slave_done_irq        <= sirq_d;
      pulse_output_pin      <= pin_d;
      pulse_output_oe       <= oe_d;
    end
  end

  a_stop_holds_cnt: assert property (@(posedge clk) disable iff (!rstn) // R24
    (mst_q == OSP_IDLE && $past(mst_q) == OSP_IDLE) |->
      $stable(master_down_counter_q)) else $error("master counter moved while stopped");
  a_mdone_zero: assert property (@(posedge clk) disable iff (!rstn) // R4
    mirq_d |-> master_down_counter_q == CNT_ZERO && mtick)
    else $error("master done not at zero");
  a_sdone_zero: assert property (@(posedge clk) disable iff (!rstn) // R6
    sirq_d |=> slave_down_counter_q == CNT_ZERO) else $error("slave done not at zero");
  a_trig_loads: assert property (@(posedge clk) disable iff (!rstn) // R3
    (mst_q == OSP_WAIT && trig && unit_power_enable_q && !(wr_ok && addr == ADR_STOP))
      |=> master_down_counter_q == $past(master_reload_value_q)) else $error("no reload");
  a_power_off: assert property (@(posedge clk) disable iff (!rstn) // R18
    !unit_power_enable_q |=> mst_q == OSP_IDLE && !slave_running_q)
    else $error("running while powered off");
  a_hiz_port: assert property (@(posedge clk) disable iff (!rstn) // R21
    !(port_q[0] && !port_q[1]) |=> !pulse_output_oe) else $error("pin driven early");
  a_pin_follows: assert property (@(posedge clk) disable iff (!rstn) // R22
    1'b1 |=> pulse_output_pin == $past(level_q)) else $error("pin not level");
  a_oe_blocks: assert property (@(posedge clk) disable iff (!rstn) // R15
    (!outcfg_q[OC_OE] && !(wr_ok && addr == ADR_OUTCFG)) |=> $stable(level_q))
    else $error("level moved with output disabled");
endmodule : osp_pulse_pair

// ===== osp_partner.sv
// Trigger source and pulse output load for the one-shot pulse pair
`timescale 1ns/10ps
module osp_partner (
  input  wire logic        clk,
  input  wire logic        active_high,
  input  wire logic        pin,
  input  wire logic        oe,
  output logic             trig,
  output logic [15:0]      width_q,
  output logic [15:0]      pulses_q
);
  logic [15:0] run_q;

  initial
  begin
    trig     = 1'b0;
    width_q  = 16'h0000;
    pulses_q = 16'h0000;
    run_q    = 16'h0000;
  end

  // Load measures each active stretch in clocks, only while driven
  always @(posedge clk)
  begin
    if (oe && (pin === active_high))
      run_q <= run_q + 16'h0001;
    else if (run_q != 16'h0000)
    begin
      width_q  <= run_q;
      pulses_q <= pulses_q + 16'h0001;
      run_q    <= 16'h0000;
    end
  end

  // Held well past the three-sample filter so the edge is not lost
  task fire;
    @(posedge clk);
    trig <= 1'b1;
    repeat (6) @(posedge clk);
    trig <= 1'b0;
  endtask : fire
endmodule : osp_partner

// ===== tb.sv
// Self-checking testbench of the one-shot pulse pair
`timescale 1ns/10ps
module tb
  import osp_pkg::*;
;
  logic          clk;
  logic          rstn;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic          wr;
  logic          rd;
  logic [DW-1:0] rdata;
  logic          trig;
  logic          pin;
  logic          oe;
  logic          mirq;
  logic          sirq;
  logic          act_hi;
  logic [15:0]   width;
  logic [15:0]   pulses;
  int            err_total;
  int            comparisons;

  osp_pulse_pair DUT (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .trigger_input_pin(trig), .pulse_output_pin(pin),
    .pulse_output_oe(oe), .master_done_irq(mirq), .slave_done_irq(sirq)
  );

  osp_partner part (
    .clk(clk), .active_high(act_hi), .pin(pin), .oe(oe), .trig(trig),
    .width_q(width), .pulses_q(pulses)
  );

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task end_sim;
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task rd_reg(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  // Stopped while reloads and modes change, then armed with both start bits
  task cfg(input logic [15:0] div, input logic [15:0] md, input logic [15:0] m,
           input logic [15:0] s, input logic [15:0] oc);
    wr_reg(ADR_STOP, 16'h0003);
    wr_reg(ADR_PRESC, div);
    wr_reg(ADR_MMODE, md | 16'h0800);
    wr_reg(ADR_SMODE, md);
    wr_reg(ADR_MRLD, m);
    wr_reg(ADR_SRLD, s);
    // Output enable off first, else the level bit of oc is not taken
    wr_reg(ADR_OUTCFG, oc & 16'hFFFD);
    wr_reg(ADR_OUTCFG, oc);
    wr_reg(ADR_PORT, 16'h0001);
    wr_reg(ADR_START, 16'h0003);
  endtask : cfg

  // Fires one trigger, returns clocks to pulse start and to master done
  task shot(input logic sw, input logic idle, output int rise, output int mat);
    int n;
    rise = -1;
    mat = -1;
    if (sw)
      wr_reg(ADR_START, 16'h0001);
    else
      part.fire();
    for (n = 1; n < 3000; n++)
    begin
      @(posedge clk);
      #1;
      if (mirq === 1'b1)
        mat = n;
      if (rise < 0 && pin !== idle)
        rise = n;
      if (sirq === 1'b1)
        break;
    end
    if (n >= 3000)
    begin
      err_total++;
      $display("ERROR slave done expected 1 seen 0");
      end_sim();
    end
    repeat (3) @(posedge clk);
    #1;
  endtask : shot

  task s_power;
    logic [15:0] d;
    chk("oe after reset", 16'h0000, {15'h0000, oe});
    wr_reg(ADR_MRLD, 16'h0055);
    wr_reg(ADR_ENABLE, 16'h0001);
    rd_reg(ADR_MRLD, d);
    chk("reload unpowered", 16'h0000, d);
    rd_reg(ADR_STATUS, d);
    chk("status idle", 16'h0000, d & 16'h0003);
    rd_reg(4'hE, d);
    chk("unmapped", 16'h0000, d);
  endtask : s_power

  task s_pin;
    wr_reg(ADR_PORT, 16'h0003);
    wr_reg(ADR_OUTCFG, 16'h0029);
    settle();
    chk("oe latch set", 16'h0000, {15'h0000, oe});
    wr_reg(ADR_PORT, 16'h0001);
    settle();
    chk("oe output", 16'h0001, {15'h0000, oe});
    chk("level high", 16'h0001, {15'h0000, pin});
    wr_reg(ADR_OUTCFG, 16'h0028);
    settle();
    chk("level low", 16'h0000, {15'h0000, pin});
  endtask : s_pin

  task s_trig;
    logic [15:0] d;
    logic [15:0] p0;
    int          r;
    int          m;
    cfg(16'h0000, 16'h0000, 16'h0006, 16'h0005, 16'h002A);
    rd_reg(ADR_STATUS, d);
    chk("running", 16'h0003, d & 16'h0003);
    rd_reg(ADR_START, d);
    chk("start reads", 16'h0000, d);
    p0 = pulses;
    shot(1'b0, 1'b0, r, m);
    chk("master done", 16'h0001, {15'h0000, m > 0});
    chk("width pin", 16'h0005, width);
    chk("pulse count", p0 + 16'h0001, pulses);
  endtask : s_trig

  task s_delay;
    int r1;
    int m1;
    int r2;
    int m2;
    cfg(16'h0000, 16'h0000, 16'h0003, 16'h0004, 16'h002A);
    shot(1'b1, 1'b0, r1, m1);
    chk("active gap", 16'h0001, {15'h0000, r1 - m1 >= 1 && r1 - m1 <= 3});
    wr_reg(ADR_MRLD, 16'h0007);
    shot(1'b1, 1'b0, r2, m2);
    chk("delay step", 16'h0004, 16'(r2 - r1));
    chk("done step", 16'h0004, 16'(m2 - m1));
    chk("width sw", 16'h0004, width);
  endtask : s_delay

  task s_tickb;
    int r;
    int m;
    cfg(16'h0020, 16'h8000, 16'h0002, 16'h0003, 16'h002A);
    shot(1'b1, 1'b0, r, m);
    chk("width tick b", 16'h000C, width);
  endtask : s_tickb

  task s_oe_off;
    logic [15:0] p0;
    int          r;
    int          m;
    cfg(16'h0000, 16'h0000, 16'h0002, 16'h0003, 16'h0029);
    p0 = pulses;
    shot(1'b1, 1'b1, r, m);
    chk("no pulse", p0, pulses);
    chk("pin held", 16'h0001, {15'h0000, pin});
    chk("done anyway", 16'h0001, {15'h0000, m > 0});
  endtask : s_oe_off

  task s_pol;
    int r;
    int m;
    act_hi = 1'b0;
    cfg(16'h0000, 16'h0000, 16'h0002, 16'h0006, 16'h002F);
    shot(1'b1, 1'b1, r, m);
    chk("width low", 16'h0006, width);
    chk("idle high", 16'h0001, {15'h0000, pin});
  endtask : s_pol

  // Slow ticks so the stop lands mid count
  task s_stop;
    logic [15:0] a;
    logic [15:0] b;
    cfg(16'h0004, 16'h0000, 16'h0064, 16'h0003, 16'h002F);
    wr_reg(ADR_START, 16'h0001);
    repeat (40) @(posedge clk);
    wr_reg(ADR_STOP, 16'h0003);
    rd_reg(ADR_STATUS, a);
    chk("stopped", 16'h0000, a & 16'h0003);
    rd_reg(ADR_STOP, a);
    chk("stop reads", 16'h0000, a);
    rd_reg(ADR_MCNT, a);
    repeat (40) @(posedge clk);
    rd_reg(ADR_MCNT, b);
    chk("count moved", 16'h0001, {15'h0000, a != 16'h0000 && a < 16'h0064});
    chk("count held", a, b);
    chk("pin stopped", 16'h0001, {15'h0000, pin});
  endtask : s_stop

  initial
  begin
    rstn        = 1'b0;
    addr        = '0;
    wdata       = '0;
    wr          = 1'b0;
    rd          = 1'b0;
    act_hi      = 1'b1;
    err_total   = 0;
    comparisons = 0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    s_power();
    s_pin();
    s_trig();
    s_delay();
    s_tickb();
    s_oe_off();
    s_pol();
    s_stop();
    end_sim();
  end
endmodule : tb
